//--- rtl/smct_defs.svh
`ifndef SMCT_DEFS_SVH
`define SMCT_DEFS_SVH

// Field widths of the per-bank wait settings and of the static port.
`define SMCT_OEN_W 4
`define SMCT_RD_W 5
`define SMCT_WEN_W 4
`define SMCT_WR_W 5
`define SMCT_CNT_W 6
`define SMCT_ADDR_W 24
`define SMCT_DATA_W 32
`define SMCT_BE_W 4
`define SMCT_BANKS 4
`define SMCT_BANK_W 2

// Reset values of the wait settings; slowest strobes are the safe default.
`define SMCT_OEN_RST 4'h0
`define SMCT_RD_RST 5'h1f
`define SMCT_WEN_RST 4'h0
`define SMCT_WR_RST 5'h1f

// Idle levels of the static port.
`define SMCT_CS_IDLE 4'hf
`define SMCT_BLS_IDLE 4'hf
`define SMCT_ADDR_RST 24'h00_0000
`define SMCT_DATA_RST 32'h0000_0000

`endif

//--- rtl/smct_pkg.sv
`include "smct_defs.svh"

package smct_pkg;

  // Wait settings kept for one chip select bank.
  typedef struct packed {
    logic [`SMCT_OEN_W-1:0] output_enable_delay;
    logic [`SMCT_RD_W-1:0] read_wait_count;
    logic [`SMCT_WEN_W-1:0] write_enable_delay;
    logic [`SMCT_WR_W-1:0] write_wait_count;
  } smct_wait_t;

  // One static access request from the internal side.
  typedef struct packed {
    logic wr;
    logic [`SMCT_BANK_W-1:0] bank;
    logic [`SMCT_ADDR_W-1:0] addr;
    logic [`SMCT_DATA_W-1:0] wdata;
    logic [`SMCT_BE_W-1:0] be;
  } smct_req_t;

  typedef enum logic [3:0] {
    SMCT_ST_IDLE = 4'b0001,
    SMCT_ST_SETUP = 4'b0010,
    SMCT_ST_STROBE = 4'b0100,
    SMCT_ST_HOLD = 4'b1000
  } smct_state_t;

  // Strobe length in bus periods: wait minus delay plus one, never below one.
  function automatic logic [`SMCT_CNT_W-1:0] smct_strobe_len(input logic [4:0] wait_cnt,
                                                               input logic [3:0] delay);
    logic [`SMCT_CNT_W-1:0] len;
    len = 6'h01;
    if ({1'b0, wait_cnt} >= {2'b00, delay}) begin
      len = 6'({1'b0, wait_cnt} - {2'b00, delay}) + 6'h01;
    end
    return len;
  endfunction

endpackage

//--- rtl/smct_rst_sync.sv
`timescale 1ns/1ps

module smct_rst_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic rst_sync_n_o
);

  logic [1:0] stage_q;

  // Reset asserts at once but releases only after two clean clock edges.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_q <= 2'b00;
    end else begin
      stage_q <= {stage_q[0], 1'b1};
    end
  end

  assign rst_sync_n_o = stage_q[1];

endmodule

//--- rtl/smct_wait_bank.sv
`timescale 1ns/1ps
`include "smct_defs.svh"

module smct_wait_bank
  import smct_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [`SMCT_BANK_W-1:0] wbank_i,
  input smct_wait_t wdata_i,
  input wire logic [`SMCT_BANK_W-1:0] rbank_i,
  output smct_wait_t rdata_o
);

  smct_wait_t bank_q [`SMCT_BANKS];
  smct_wait_t bank_d [`SMCT_BANKS];

  // A write replaces the settings of the addressed bank only.
  always_comb begin
    for (int i = 0; i < `SMCT_BANKS; i++) begin
      bank_d[i] = bank_q[i];
    end
    if (we_i) begin
      bank_d[wbank_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `SMCT_BANKS; i++) begin
        bank_q[i] <= '{`SMCT_OEN_RST, `SMCT_RD_RST, `SMCT_WEN_RST, `SMCT_WR_RST};
      end
    end else begin
      for (int i = 0; i < `SMCT_BANKS; i++) begin
        bank_q[i] <= bank_d[i];
      end
    end
  end

  // Read is combinational so a request can latch its bank's settings at once.
  assign rdata_o = bank_q[rbank_i];

endmodule

//--- rtl/smct_static_timing.sv
`timescale 1ns/1ps
`include "smct_defs.svh"

module smct_static_timing
  import smct_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input smct_req_t req_i,
  output logic req_ready_o,
  output logic busy_o,
  output logic rd_valid_o,
  output logic [`SMCT_DATA_W-1:0] rd_data_o,
  input wire logic cfg_we_i,
  input wire logic [`SMCT_BANK_W-1:0] cfg_bank_i,
  input smct_wait_t cfg_wait_i,
  output logic [`SMCT_BANKS-1:0] mem_cs_n_o,
  output logic [`SMCT_ADDR_W-1:0] mem_addr_o,
  output logic mem_oe_n_o,
  output logic mem_we_n_o,
  output logic [`SMCT_BE_W-1:0] mem_bls_n_o,
  output logic [`SMCT_DATA_W-1:0] mem_data_o,
  output logic mem_data_oe_n_o,
  input wire logic [`SMCT_DATA_W-1:0] mem_data_i
);

  logic rst_n;
  smct_wait_t bank_cfg;

  smct_state_t st_q, st_d;
  logic [`SMCT_CNT_W-1:0] cnt_q, cnt_d;
  smct_wait_t cfg_q, cfg_d;
  logic wr_q, wr_d;
  logic [`SMCT_BE_W-1:0] be_q, be_d;
  logic ready_q, ready_d;
  logic busy_q, busy_d;
  logic [`SMCT_BANKS-1:0] cs_n_q, cs_n_d;
  logic [`SMCT_ADDR_W-1:0] addr_q, addr_d;
  logic oe_n_q, oe_n_d;
  logic we_n_q, we_n_d;
  logic [`SMCT_BE_W-1:0] bls_n_q, bls_n_d;
  logic [`SMCT_DATA_W-1:0] data_q, data_d;
  logic doe_n_q, doe_n_d;
  logic [`SMCT_CNT_W-1:0] rd_len, wr_len;

  logic [`SMCT_DATA_W-1:0] sync1_q, sync2_q;
  logic tag1_q, tag1_d;
  logic tag2_q;
  logic rvalid_q, rvalid_d;
  logic [`SMCT_DATA_W-1:0] rdata_q, rdata_d;

  smct_rst_sync u_rst_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .rst_sync_n_o(rst_n)
  );

  // Settings are read by the bank of the incoming request.
  // per-bank settings
  smct_wait_bank u_wait_bank (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .we_i(cfg_we_i),
    .wbank_i(cfg_bank_i),
    .wdata_i(cfg_wait_i),
    .rbank_i(req_i.bank),
    .rdata_o(bank_cfg)
  );

  // Strobe lengths of the access in flight; a wait below its delay gives one period.
  assign rd_len = smct_strobe_len(cfg_q.read_wait_count, cfg_q.output_enable_delay);
  assign wr_len = smct_strobe_len(cfg_q.write_wait_count, cfg_q.write_enable_delay);

  // Access sequencer: idle, chip select set-up, strobe, one period of hold.
  // Settings are latched at acceptance, so a config write mid-access cannot corrupt it.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    cfg_d = cfg_q;
    wr_d = wr_q;
    be_d = be_q;
    ready_d = ready_q;
    busy_d = busy_q;
    cs_n_d = cs_n_q;
    addr_d = addr_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    bls_n_d = bls_n_q;
    data_d = data_q;
    doe_n_d = doe_n_q;
    unique case (st_q)
      SMCT_ST_IDLE: begin
        if (req_valid_i && ready_q) begin
          cfg_d = bank_cfg;
          wr_d = req_i.wr;
          be_d = req_i.be;
          ready_d = 1'b0;
          busy_d = 1'b1;
          cs_n_d = ~(`SMCT_BANKS'(1) << req_i.bank);
          addr_d = req_i.addr;
          if (req_i.wr) begin
            data_d = req_i.wdata;
            doe_n_d = 1'b0;
            st_d = SMCT_ST_SETUP;
            cnt_d = `SMCT_CNT_W'(bank_cfg.write_enable_delay);
          end else if (bank_cfg.output_enable_delay == 4'h0) begin
            st_d = SMCT_ST_STROBE;
            cnt_d = smct_strobe_len(bank_cfg.read_wait_count, 4'h0) - 6'h01;
            oe_n_d = 1'b0;
            bls_n_d = ~req_i.be;
          end else begin
            st_d = SMCT_ST_SETUP;
            cnt_d = `SMCT_CNT_W'(bank_cfg.output_enable_delay) - 6'h01;
          end
        end
      end
      SMCT_ST_SETUP: begin
        if (cnt_q == 6'h00) begin
          st_d = SMCT_ST_STROBE;
          bls_n_d = ~be_q;
          if (wr_q) begin
            we_n_d = 1'b0;
            cnt_d = wr_len - 6'h01;
          end else begin
            oe_n_d = 1'b0;
            cnt_d = rd_len - 6'h01;
          end
        end else begin
          cnt_d = cnt_q - 6'h01;
        end
      end
      SMCT_ST_STROBE: begin
        if (cnt_q == 6'h00) begin
          st_d = SMCT_ST_HOLD;
          cs_n_d = `SMCT_CS_IDLE;
          oe_n_d = 1'b1;
          we_n_d = 1'b1;
          bls_n_d = `SMCT_BLS_IDLE;
        end else begin
          cnt_d = cnt_q - 6'h01;
        end
      end
      SMCT_ST_HOLD: begin
        st_d = SMCT_ST_IDLE;
        doe_n_d = 1'b1;
        ready_d = 1'b1;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SMCT_ST_IDLE;
      cnt_q <= 6'h00;
      cfg_q <= '{`SMCT_OEN_RST, `SMCT_RD_RST, `SMCT_WEN_RST, `SMCT_WR_RST};
      wr_q <= 1'b0;
      be_q <= 4'h0;
      ready_q <= 1'b1;
      busy_q <= 1'b0;
      cs_n_q <= `SMCT_CS_IDLE;
      addr_q <= `SMCT_ADDR_RST;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      bls_n_q <= `SMCT_BLS_IDLE;
      data_q <= `SMCT_DATA_RST;
      doe_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cfg_q <= cfg_d;
      wr_q <= wr_d;
      be_q <= be_d;
      ready_q <= ready_d;
      busy_q <= busy_d;
      cs_n_q <= cs_n_d;
      addr_q <= addr_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      bls_n_q <= bls_n_d;
      data_q <= data_d;
      doe_n_q <= doe_n_d;
    end
  end

  // Read capture: the pins are sampled on the edge that ends the strobe, where
  // the memory still holds its data, then cross two flops before use.
  // sample before release
  always_comb begin
    tag1_d = (st_q == SMCT_ST_STROBE) && (cnt_q == 6'h00) && !wr_q;
    rvalid_d = tag2_q;
    rdata_d = tag2_q ? sync2_q : rdata_q;
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= `SMCT_DATA_RST;
      sync2_q <= `SMCT_DATA_RST;
      tag1_q <= 1'b0;
      tag2_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= `SMCT_DATA_RST;
    end else begin
      sync1_q <= mem_data_i;
      sync2_q <= sync1_q;
      tag1_q <= tag1_d;
      tag2_q <= tag1_q;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
    end
  end

  assign req_ready_o = ready_q;
  assign busy_o = busy_q;
  assign rd_valid_o = rvalid_q;
  assign rd_data_o = rdata_q;
  assign mem_cs_n_o = cs_n_q;
  assign mem_addr_o = addr_q;
  assign mem_oe_n_o = oe_n_q;
  assign mem_we_n_o = we_n_q;
  assign mem_bls_n_o = bls_n_q;
  assign mem_data_o = data_q;
  assign mem_data_oe_n_o = doe_n_q;

  // Checking helpers: periods since select fell, and periods a strobe has been low.
  logic cs_any_n;
  logic [7:0] since_cs_q;
  logic [7:0] low_q;
  assign cs_any_n = &mem_cs_n_o;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      since_cs_q <= 8'h00;
      low_q <= 8'h00;
    end else begin
      since_cs_q <= cs_any_n ? 8'h00 : since_cs_q + 8'h01;
      low_q <= (mem_oe_n_o && mem_we_n_o) ? 8'h00 : low_q + 8'h01;
    end
  end

  a_cs_addr_valid: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(cs_any_n) |-> mem_addr_o == $past(req_i.addr))
    else $error("Address not valid when chip select fell.");

  a_oe_fall_delay: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(mem_oe_n_o) |-> since_cs_q == 8'(cfg_q.output_enable_delay))
    else $error("Output enable fell at the wrong period after chip select.");

  a_bls_read_lanes: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (busy_q && !wr_q) |-> mem_bls_n_o == (mem_oe_n_o ? `SMCT_BLS_IDLE : ~be_q))
    else $error("Read lane strobes do not follow output enable.");

  a_oe_low_width: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(mem_oe_n_o) |-> low_q == 8'(rd_len))
    else $error("Output enable low for the wrong number of periods.");

  a_cs_rise_read: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(mem_oe_n_o) |-> $rose(cs_any_n) && mem_bls_n_o == `SMCT_BLS_IDLE)
    else $error("Chip select did not rise with output enable.");

  a_read_addr_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(mem_oe_n_o) |=> $stable(mem_addr_o))
    else $error("Address changed in the period after a read strobe.");

  a_wdata_with_cs: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    ($fell(cs_any_n) && wr_q) |-> !mem_data_oe_n_o && mem_data_o == $past(req_i.wdata))
    else $error("Write data not driven when chip select fell.");

  a_we_fall_delay: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(mem_we_n_o) |-> since_cs_q == 8'(cfg_q.write_enable_delay) + 8'h01 && mem_bls_n_o == ~be_q)
    else $error("Write strobe fell at the wrong period after chip select.");

  a_we_low_width: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(mem_we_n_o) |-> low_q == 8'(wr_len))
    else $error("Write strobe low for the wrong number of periods.");

  a_write_data_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(mem_we_n_o) |-> $stable(mem_addr_o) && $stable(mem_data_o) && !mem_data_oe_n_o)
    else $error("Address or data changed in the period after a write strobe.");

  a_read_capture_lat: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(mem_oe_n_o) |-> ##2 rd_valid_o ##1 !rd_valid_o)
    else $error("Read data not returned two periods after the strobe ended.");

  c_read_zero_delay: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(cs_any_n) && !mem_oe_n_o);
  c_write_access: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(mem_we_n_o));
  c_back_to_back: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(cs_any_n) ##2 $fell(cs_any_n));

endmodule

//--- test/smct_mem_model.sv
`timescale 1ns/1ps
`include "smct_defs.svh"

// Behavioural static memory of sixteen words on the far side of the port.
module smct_mem_model
  import smct_pkg::*;
(
  input wire logic clk_i,
  input wire logic [`SMCT_BANKS-1:0] cs_n_i,
  input wire logic [`SMCT_ADDR_W-1:0] addr_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [`SMCT_BE_W-1:0] bls_n_i,
  input wire logic [`SMCT_DATA_W-1:0] wdata_i,
  input wire logic wdata_oe_n_i,
  output logic [`SMCT_DATA_W-1:0] rdata_o
);
  logic [`SMCT_DATA_W-1:0] mem_q [16];
  logic sel;

  // Any low chip select counts as selected.
  assign sel = (cs_n_i != `SMCT_CS_IDLE);

  // A released bus shows the inverse word, so a late sample never matches by luck.
  // read data only while output enable is low, no hold
  always_comb begin
    rdata_o = ~mem_q[addr_i[3:0]];
    if (!wdata_oe_n_i) begin
      rdata_o = wdata_i;
    end else if (sel && !oe_n_i) begin
      rdata_o = mem_q[addr_i[3:0]];
    end
  end

  // Lanes are written at every strobe edge; the last edge wins.
  always @(posedge clk_i) begin
    if (sel && !we_n_i) begin
      for (int i = 0; i < 4; i++) begin
        if (!bls_n_i[i]) begin
          mem_q[addr_i[3:0]][8*i +: 8] <= wdata_i[8*i +: 8];
        end
      end
    end
  end

  // Memory content is not touched by the controller's reset.
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_q[i] = 32'h0000_0000;
    end
  end
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
`include "smct_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
  import smct_pkg::*;
  typedef struct {smct_req_t req; int dly; int len;} smct_tb_row_t;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  smct_req_t req_i = '0;
  logic cfg_we_i = 1'b0;
  logic [1:0] cfg_bank_i = 2'h0;
  smct_wait_t cfg_wait_i = '0;
  logic req_ready_o, busy_o, rd_valid_o, mem_oe_n_o, mem_we_n_o, mem_data_oe_n_o;
  logic [31:0] rd_data_o, mem_data_o, mem_data_i;
  logic [3:0] mem_cs_n_o, mem_bls_n_o;
  logic [23:0] mem_addr_o;
  logic [31:0] shadow [16];
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  // Per bank: delay, read wait, write delay, write wait; bank 2 has wait below delay.
  smct_wait_t cfg_tab [4] = '{'{4'h0, 5'h00, 4'h0, 5'h00}, '{4'h1, 5'h02, 4'h0, 5'h01},
                              '{4'h3, 5'h01, 4'h2, 5'h05}, '{4'hf, 5'h1f, 4'hf, 5'h1f}};
  // Request, expected strobe delay after select, expected strobe length.
  smct_tb_row_t rows [8] = '{
    '{'{1'b1, 2'h0, 24'h00_0001, 32'ha5a5_5a5a, 4'hf}, 1, 1},
    '{'{1'b0, 2'h0, 24'h00_0001, 32'h0000_0000, 4'hf}, 0, 1},
    '{'{1'b1, 2'h1, 24'h12_3452, 32'h1234_5678, 4'h5}, 1, 2},
    '{'{1'b0, 2'h1, 24'h12_3452, 32'h0000_0000, 4'hf}, 1, 2},
    '{'{1'b1, 2'h2, 24'hff_fff3, 32'hdead_beef, 4'ha}, 3, 4},
    '{'{1'b0, 2'h2, 24'hff_fff3, 32'h0000_0000, 4'h3}, 3, 1},
    '{'{1'b1, 2'h3, 24'h80_0004, 32'h0f0f_f0f0, 4'hf}, 16, 17},
    '{'{1'b0, 2'h3, 24'h80_0004, 32'h0000_0000, 4'hc}, 15, 17}};

  smct_static_timing dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .busy_o(busy_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .cfg_we_i(cfg_we_i), .cfg_bank_i(cfg_bank_i), .cfg_wait_i(cfg_wait_i),
    .mem_cs_n_o(mem_cs_n_o), .mem_addr_o(mem_addr_o), .mem_oe_n_o(mem_oe_n_o),
    .mem_we_n_o(mem_we_n_o), .mem_bls_n_o(mem_bls_n_o), .mem_data_o(mem_data_o),
    .mem_data_oe_n_o(mem_data_oe_n_o), .mem_data_i(mem_data_i));

  smct_mem_model mem (.clk_i(core_clk_i), .cs_n_i(mem_cs_n_o), .addr_i(mem_addr_o),
    .oe_n_i(mem_oe_n_o), .we_n_i(mem_we_n_o), .bls_n_i(mem_bls_n_o), .wdata_i(mem_data_o),
    .wdata_oe_n_i(mem_data_oe_n_o), .rdata_o(mem_data_i));

  // Free running bus clock of 8 ns.
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  // A hung handshake ends the run well after the longest sequence.
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("err_total=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Writes one bank's settings; takes effect for later requests.
  task automatic set_bank(input logic [1:0] b, input smct_wait_t w);
    cfg_we_i = 1'b1;
    cfg_bank_i = b;
    cfg_wait_i = w;
    @(negedge core_clk_i);
    cfg_we_i = 1'b0;
    // Let an edge pass low so the next call does not raise the strobe it just lowered.
    @(negedge core_clk_i);
  endtask

  // One access, measured at falling edges where the registered pins have settled.
  task automatic run(input smct_req_t r, input int dly, input int len);
    int n, d, s;
    n = 0;
    d = -1;
    s = 0;
    while (req_ready_o !== 1'b1 && n < 64) begin
      n++;
      @(negedge core_clk_i);
    end
    n = 0;
    req_i = r;
    req_valid_i = 1'b1;
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    `CHK(mem_cs_n_o, ~(4'h1 << r.bank))
    `CHK(mem_addr_o, r.addr)
    `CHK({busy_o, req_ready_o}, 2'b10)
    if (r.wr) `CHK({mem_data_oe_n_o, mem_data_o}, {1'b0, r.wdata})
    while (mem_cs_n_o !== 4'hf && n < 64) begin
      if ((r.wr ? mem_we_n_o : mem_oe_n_o) === 1'b0) begin
        if (s == 0) `CHK(mem_bls_n_o, ~r.be)
        if (s == 0) d = n;
        s++;
      end
      `CHK(mem_addr_o, r.addr)
      n++;
      @(negedge core_clk_i);
    end
    `CHK(d, dly)
    `CHK(s, len)
    `CHK(n, dly + len)
    `CHK({mem_oe_n_o, mem_we_n_o, mem_bls_n_o}, 6'h3f)
    `CHK(mem_addr_o, r.addr)
    if (r.wr) begin
      `CHK({mem_data_oe_n_o, mem_data_o}, {1'b0, r.wdata})
      for (int i = 0; i < 4; i++) begin
        if (r.be[i]) shadow[r.addr[3:0]][8*i +: 8] = r.wdata[8*i +: 8];
      end
      // The bus is let go only after the one period of hold.
      @(negedge core_clk_i);
      `CHK(mem_data_oe_n_o, 1'b1)
    end else begin
      `CHK(mem_data_oe_n_o, 1'b1)
      n = 0;
      while (rd_valid_o !== 1'b1 && n < 4) begin
        n++;
        @(negedge core_clk_i);
      end
      `CHK(rd_valid_o, 1'b1)
      `CHK(rd_data_o, shadow[r.addr[3:0]])
    end
    `CHK({busy_o, req_ready_o}, 2'b01)
  endtask

  // Main sequence: table rows first, then a mid-run reset with default settings.
  initial begin
    for (int i = 0; i < 16; i++) shadow[i] = 32'h0000_0000;
    repeat (16) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    for (int b = 0; b < 4; b++) set_bank(2'(b), cfg_tab[b]);
    foreach (rows[i]) run(rows[i].req, rows[i].dly, rows[i].len);
    // Reset lands in the middle of a slow read, while output enable is low.
    req_i = '{1'b0, 2'h3, 24'h80_0004, 32'h0000_0000, 4'hf};
    req_valid_i = 1'b1;
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    repeat (18) @(negedge core_clk_i);
    `CHK(mem_oe_n_o, 1'b0)
    rst_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    `CHK({mem_cs_n_o, mem_oe_n_o, mem_we_n_o, mem_bls_n_o, mem_data_oe_n_o}, 11'h7ff)
    `CHK(mem_addr_o, 24'h00_0000)
    `CHK({busy_o, req_ready_o, rd_valid_o}, 3'b010)
    rst_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    // Settings fall back to the slowest strobes in every bank.
    run('{1'b0, 2'h1, 24'h00_0002, 32'h0000_0000, 4'hf}, 0, 32);
    run('{1'b1, 2'h2, 24'h00_0003, 32'h5555_aaaa, 4'h9}, 1, 32);
    run('{1'b0, 2'h0, 24'h00_0003, 32'h0000_0000, 4'hf}, 0, 32);
    report_and_stop();
  end
endmodule
